// ---- hdl/tmhp_pkg.sv ----
// shared constants and types of the time manager host port
package tmhp_pkg;
    // ****************************************
    // register map
    // ****************************************
    localparam logic [4:0] TMHP_CTRL_ADDR = 5'h1b;
    localparam logic [4:0] TMHP_STAMP_LAST_ADDR = 5'h14;
    localparam logic [15:0] TMHP_CTRL_RESET = 16'h0000;
    localparam logic [15:0] TMHP_CTRL_WMASK = 16'h01ec;

    // ****************************************
    // control register field positions
    // ****************************************
    localparam int TMHP_BIT_WINDOW = 0;
    localparam int TMHP_BIT_ALARM = 1;
    localparam int TMHP_BIT_STAMP = 2;
    localparam int TMHP_BIT_PHASE = 3;
    localparam int TMHP_BIT_WAVE = 4;
    localparam int TMHP_BIT_USER_LO = 5;
    localparam int TMHP_BIT_USER_HI = 8;
    localparam int TMHP_BIT_VALID = 9;

    // ****************************************
    // widths and families
    // ****************************************
    localparam int TMHP_AW = 5;
    localparam int TMHP_DW = 16;
    localparam logic TMHP_FAMILY_FALL = 1'b0;
    localparam logic TMHP_FAMILY_RISE = 1'b1;

    // pins from outside, resynchronised as one bundle
    typedef struct packed {
        logic mproc_clk;
        logic family_sel;
        logic cs_n;
        logic rd_n;
        logic wr_n;
        logic phase_in;
        logic stamp_strobe;
        logic [TMHP_AW-1:0] addr;
        logic [TMHP_DW-1:0] data;
    } tmhp_pins_s;

    typedef enum logic [1:0] {
        TMHP_IDLE,
        TMHP_READ_WAIT,
        TMHP_HOLD
    } tmhp_state_e;
endpackage

// ---- hdl/tmhp_port.sv ----
// host port and low control bits of the time manager
// Function
// [R1] every register can be read and written over the processor port
// [R2] host drives select, read, write in step with the processor clock
// [R3] strobes sampled on falling clock edge for family 0, rising for 1
// [R4] family 1: ready low when a cycle completes; family 0: ready stays high
// [R5] with auxiliary crystal 0, processor clock at least twice serial bus clock
// [R6] processor clock no faster than the crystal input
// [R7] phase bit set by written one or rising edge of phase input
// [R8] every phase input rising edge reaches waveform generator even when bit high
// [R9] writing one to a set phase bit gives no extra phase event
// [R10] stamp bit set by written one or strobe edge; both start capture; here a written one starts capture only while the bit is clear
// [R11] stamp bit cleared at the end of a read of address 20
// [R12] control bit 1 mirrors the alarm output level
// [R13] control bit 0 mirrors the window output level
// [R14] control writes keep read-only bits; control reads change nothing
// [R15] control register at address 27, writable bits 2, 3, 5 to 8
// [R16] input rising edges detected internally, each setting its bit once
`timescale 1ns/1ps
module tmhp_port #(
    parameter int AW = tmhp_pkg::TMHP_AW,
    parameter int DW = tmhp_pkg::TMHP_DW
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic mproc_clk_i,
    input wire logic family_sel_i,
    input wire logic cs_n_i,
    input wire logic rd_n_i,
    input wire logic wr_n_i,
    input wire logic [AW-1:0] addr_i,
    input wire logic [DW-1:0] data_i,
    output logic [DW-1:0] data_o,
    output logic data_oe_n_o,
    output logic ready_n_o,
    input wire logic phase_in_i,
    input wire logic stamp_strobe_i,
    input wire logic alarm_i,
    input wire logic window_i,
    input wire logic wave_i,
    input wire logic time_valid_i,
    output logic phase_event_o,
    output logic stamp_capture_o,
    output logic [3:0] ctrl_user_o
);
    // ****************************************
    // pin synchronisers
    // ****************************************
    tmhp_pkg::tmhp_pins_s pins_in;
    tmhp_pkg::tmhp_pins_s pin_meta_r;
    tmhp_pkg::tmhp_pins_s pin_sync_r;
    tmhp_pkg::tmhp_pins_s pin_last_r;

    assign pins_in = '{mproc_clk: mproc_clk_i, family_sel: family_sel_i, cs_n: cs_n_i, rd_n: rd_n_i,
                       wr_n: wr_n_i, phase_in: phase_in_i, stamp_strobe: stamp_strobe_i,
                       addr: addr_i, data: data_i};

    // reset values: host idle, all strobes released
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            pin_meta_r <= '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, default: '0};
            pin_sync_r <= '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, default: '0};
            pin_last_r <= '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, default: '0};
        end else if (ce_i) begin
            pin_meta_r <= pins_in;
            pin_sync_r <= pin_meta_r;
            pin_last_r <= pin_sync_r;
        end
    end

    // ****************************************
    // sampling edge and access decode
    // ****************************************
    logic clk_rise;
    logic clk_fall;
    logic sample_edge;
    logic req_read;
    logic req_write;
    logic is_ctrl;

    assign clk_rise = pin_sync_r.mproc_clk && !pin_last_r.mproc_clk;
    assign clk_fall = !pin_sync_r.mproc_clk && pin_last_r.mproc_clk;
    assign sample_edge = (pin_sync_r.family_sel == tmhp_pkg::TMHP_FAMILY_RISE) ? clk_rise : clk_fall; // [R3]
    // write wins when the host asserts both strobes
    assign req_write = !pin_sync_r.cs_n && !pin_sync_r.wr_n;
    assign req_read = !pin_sync_r.cs_n && !pin_sync_r.rd_n && pin_sync_r.wr_n;
    assign is_ctrl = (pin_sync_r.addr == tmhp_pkg::TMHP_CTRL_ADDR); // [R15]

    // ****************************************
    // cycle state machine
    // ****************************************
    tmhp_pkg::tmhp_state_e state_r;
    tmhp_pkg::tmhp_state_e state_nxt;
    logic [AW-1:0] cyc_addr_r;
    logic cyc_read_r;
    logic cyc_ctrl_r;
    logic take_write;
    logic take_read;
    logic cycle_end;

    assign take_write = sample_edge && (state_r == tmhp_pkg::TMHP_IDLE) && req_write;
    assign take_read = sample_edge && (state_r == tmhp_pkg::TMHP_IDLE) && req_read;
    assign cycle_end = sample_edge && (state_r == tmhp_pkg::TMHP_HOLD) && pin_sync_r.cs_n;

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            tmhp_pkg::TMHP_IDLE: begin
                if (take_read) begin
                    state_nxt = tmhp_pkg::TMHP_READ_WAIT;
                end else if (take_write) begin
                    state_nxt = tmhp_pkg::TMHP_HOLD;
                end
            end
            tmhp_pkg::TMHP_READ_WAIT: begin
                state_nxt = tmhp_pkg::TMHP_HOLD;
            end
            tmhp_pkg::TMHP_HOLD: begin
                if (cycle_end) begin
                    state_nxt = tmhp_pkg::TMHP_IDLE;
                end
            end
            // unused fourth code falls back to idle
            default: begin
                state_nxt = tmhp_pkg::TMHP_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            state_r <= tmhp_pkg::TMHP_IDLE;
        end else if (ce_i) begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            cyc_addr_r <= '0;
            cyc_read_r <= 1'b0;
            cyc_ctrl_r <= 1'b0;
        end else if (ce_i && (take_read || take_write)) begin
            cyc_addr_r <= pin_sync_r.addr;
            cyc_read_r <= take_read;
            cyc_ctrl_r <= is_ctrl;
        end
    end

    // ****************************************
    // storage words for every other address
    // ****************************************
    logic [DW-1:0] mem_rdata;

    tmhp_regmem #(
        .AW(AW),
        .DW(DW)
    ) u_regmem (
        .ref_clk_i(ref_clk_i),
        .ce_i(ce_i),
        .we_i(take_write && !is_ctrl), // [R1]
        .addr_i(pin_sync_r.addr),
        .wdata_i(pin_sync_r.data),
        .rdata_o(mem_rdata)
    );

    // ****************************************
    // control register, live bits
    // ****************************************
    logic ctrl_wr;
    logic [DW-1:0] wdata;
    logic phase_rise;
    logic strobe_rise;
    logic phase_bit_r;
    logic stamp_bit_r;
    logic [3:0] user_bits_r;
    logic stamp_clear;
    logic [DW-1:0] ctrl_view;

    assign ctrl_wr = take_write && is_ctrl;
    assign wdata = pin_sync_r.data & tmhp_pkg::TMHP_CTRL_WMASK; // [R14]
    // edges taken from synchronised copies, one pulse per edge
    assign phase_rise = pin_sync_r.phase_in && !pin_last_r.phase_in; // [R16]
    assign strobe_rise = pin_sync_r.stamp_strobe && !pin_last_r.stamp_strobe; // [R16]
    assign stamp_clear = cycle_end && cyc_read_r && (cyc_addr_r == tmhp_pkg::TMHP_STAMP_LAST_ADDR); // [R11]

    // set from the pin wins over a written zero in the same cycle
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            phase_bit_r <= tmhp_pkg::TMHP_CTRL_RESET[tmhp_pkg::TMHP_BIT_PHASE];
        end else if (ce_i) begin
            if (phase_rise) begin
                phase_bit_r <= 1'b1; // [R7]
            end else if (ctrl_wr) begin
                phase_bit_r <= wdata[tmhp_pkg::TMHP_BIT_PHASE]; // [R7]
            end
        end
    end

    // set wins over the end-of-read clear
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            stamp_bit_r <= tmhp_pkg::TMHP_CTRL_RESET[tmhp_pkg::TMHP_BIT_STAMP];
        end else if (ce_i) begin
            if (strobe_rise || (ctrl_wr && wdata[tmhp_pkg::TMHP_BIT_STAMP])) begin
                stamp_bit_r <= 1'b1; // [R10]
            end else if (stamp_clear) begin
                stamp_bit_r <= 1'b0; // [R11]
            end else if (ctrl_wr) begin
                stamp_bit_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            user_bits_r <= tmhp_pkg::TMHP_CTRL_RESET[tmhp_pkg::TMHP_BIT_USER_HI:tmhp_pkg::TMHP_BIT_USER_LO];
        end else if (ce_i && ctrl_wr) begin
            user_bits_r <= wdata[tmhp_pkg::TMHP_BIT_USER_HI:tmhp_pkg::TMHP_BIT_USER_LO]; // [R15]
        end
    end

    // a written one only counts as an event when the bit was clear
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            phase_event_o <= 1'b0;
            stamp_capture_o <= 1'b0;
        end else if (ce_i) begin
            phase_event_o <= phase_rise
                || (ctrl_wr && wdata[tmhp_pkg::TMHP_BIT_PHASE] && !phase_bit_r); // [R8] [R9]
            stamp_capture_o <= strobe_rise
                || (ctrl_wr && wdata[tmhp_pkg::TMHP_BIT_STAMP] && !stamp_bit_r); // [R10]
        end
    end

    assign ctrl_user_o = user_bits_r;

    always_comb begin
        ctrl_view = '0;
        ctrl_view[tmhp_pkg::TMHP_BIT_WINDOW] = window_i; // [R13]
        ctrl_view[tmhp_pkg::TMHP_BIT_ALARM] = alarm_i; // [R12]
        ctrl_view[tmhp_pkg::TMHP_BIT_STAMP] = stamp_bit_r;
        ctrl_view[tmhp_pkg::TMHP_BIT_PHASE] = phase_bit_r;
        ctrl_view[tmhp_pkg::TMHP_BIT_WAVE] = wave_i;
        ctrl_view[tmhp_pkg::TMHP_BIT_USER_HI:tmhp_pkg::TMHP_BIT_USER_LO] = user_bits_r;
        ctrl_view[tmhp_pkg::TMHP_BIT_VALID] = time_valid_i;
    end

    // ****************************************
    // read data and ready
    // ****************************************
    // read data is frozen for the whole hold phase, so a slow host sees a stable word
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            data_o <= '0;
        end else if (ce_i && state_r == tmhp_pkg::TMHP_READ_WAIT) begin
            data_o <= cyc_ctrl_r ? ctrl_view : mem_rdata; // [R1] [R14]
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            data_oe_n_o <= 1'b1;
        end else if (ce_i) begin
            data_oe_n_o <= !((state_r == tmhp_pkg::TMHP_READ_WAIT)
                || (state_r == tmhp_pkg::TMHP_HOLD && cyc_read_r && !cycle_end));
        end
    end

    // ready only in the rising-edge family; stays high otherwise
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            ready_n_o <= 1'b1;
        end else if (ce_i) begin
            ready_n_o <= !((pin_sync_r.family_sel == tmhp_pkg::TMHP_FAMILY_RISE)
                && (state_nxt == tmhp_pkg::TMHP_HOLD)); // [R4]
        end
    end
endmodule

// ---- hdl/tmhp_regmem.sv ----
// storage words behind the host port, registered read data
`timescale 1ns/1ps
module tmhp_regmem #(
    parameter int AW = 5,
    parameter int DW = 16
) (
    input wire logic ref_clk_i,
    input wire logic ce_i,
    input wire logic we_i,
    input wire logic [AW-1:0] addr_i,
    input wire logic [DW-1:0] wdata_i,
    output logic [DW-1:0] rdata_o
);
    logic [DW-1:0] mem_r [0:(1<<AW)-1];

    always_ff @(posedge ref_clk_i) begin
        if (ce_i && we_i) begin
            mem_r[addr_i] <= wdata_i;
        end
    end

    // no reset on the array: contents are undefined until written
    always_ff @(posedge ref_clk_i) begin
        if (ce_i) begin
            rdata_o <= mem_r[addr_i];
        end
    end
endmodule

// ---- verif/time_manager_host_port_ctrl_test.sv ----
// self-checking bench of the time manager host port
`timescale 1ns/1ps
module time_manager_host_port_ctrl_test;
    logic ref_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic family_sel_i = 1'b0;
    logic [1:0] pins = 2'b00;
    logic [3:0] lv = 4'h0;
    logic oe_q = 1'b1;
    logic mclk, cs_n, rd_n, wr_n, oe_n, rdy_n, ph_ev, st_cap;
    logic [4:0] addr;
    logic [15:0] wdata, rdata;
    logic [3:0] user;
    logic [15:0] exp_q[$];
    logic [31:0] seed = 32'h84bad26e;
    int bad_count = 0;
    int checked = 0;
    int ph_n = 0;
    int st_n = 0;
    always #50 ref_clk_i = ~ref_clk_i;
    tmhp_host tmhp_host_inst (.ref_clk_i(ref_clk_i), .family_sel_i(family_sel_i), .mproc_clk_o(mclk),
        .cs_n_o(cs_n), .rd_n_o(rd_n), .wr_n_o(wr_n), .addr_o(addr), .data_o(wdata));
    tmhp_port tmhp_port_inst (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .ce_i(1'b1), .mproc_clk_i(mclk),
        .family_sel_i(family_sel_i), .cs_n_i(cs_n), .rd_n_i(rd_n), .wr_n_i(wr_n), .addr_i(addr),
        .data_i(wdata), .data_o(rdata), .data_oe_n_o(oe_n), .ready_n_o(rdy_n), .phase_in_i(pins[0]),
        .stamp_strobe_i(pins[1]), .alarm_i(lv[0]), .window_i(lv[1]), .wave_i(lv[2]), .time_valid_i(lv[3]),
        .phase_event_o(ph_ev), .stamp_capture_o(st_cap), .ctrl_user_o(user));
    // ****************************************
    // checking helpers
    // ****************************************
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [15:0] c27(input logic [3:0] u, input logic p, input logic s);
        return {6'h00, lv[3], u, lv[2], p, s, lv[0], lv[1]};
    endfunction
    task automatic cmp(input string what, input logic [15:0] e, input logic [15:0] s);
        checked++;
        if (s !== e) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, e, s);
        end
    endtask
    task automatic cmp_cnt(input string what, input int e, input int s);
        cmp(what, 16'(e), 16'(s));
    endtask
    task automatic end_of_test();
        $display("compares %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        tmhp_host_inst.access(1'b1, a, d);
    endtask
    task automatic rd(input logic [4:0] a, input logic [15:0] e);
        exp_q.push_back(e);
        tmhp_host_inst.access(1'b0, a, ~e);
    endtask
    task automatic pin_pulse(input int k);
        @(negedge ref_clk_i);
        pins[k] = 1'b1;
        repeat (6) @(negedge ref_clk_i);
        pins[k] = 1'b0;
        repeat (6) @(negedge ref_clk_i);
    endtask
    // read words checked when the device starts driving them, half a cycle after the launching edge
    always @(negedge ref_clk_i) begin
        if (oe_q === 1'b1 && oe_n === 1'b0) cmp("read", exp_q.size() ? exp_q.pop_front() : ~rdata, rdata);
        oe_q <= oe_n;
        if (ph_ev === 1'b1) ph_n++;
        if (st_cap === 1'b1) st_n++;
    end
    initial begin
        #3000000;
        bad_count++;
        end_of_test();
    end
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        logic [31:0] r;
        repeat (12) @(negedge ref_clk_i);
        rst_i = 1'b0;
        for (int i = 0; i < 4; i++) begin
            family_sel_i = i[0];
            r = rnd();
            lv = r[24:21];
            wr(5'(r[20:16] % 27), r[15:0]);
            rd(5'(r[20:16] % 27), r[15:0]);
        end
        wr(tmhp_pkg::TMHP_CTRL_ADDR, 16'hffff);
        rd(tmhp_pkg::TMHP_CTRL_ADDR, c27(4'hf, 1'b1, 1'b1));
        cmp("user bits", 16'h000f, {12'h000, user});
        wr(tmhp_pkg::TMHP_CTRL_ADDR, 16'hffff);
        rd(tmhp_pkg::TMHP_CTRL_ADDR, c27(4'hf, 1'b1, 1'b1));
        pin_pulse(0);
        pin_pulse(1);
        family_sel_i = 1'b0;
        wr(tmhp_pkg::TMHP_STAMP_LAST_ADDR, 16'h1234);
        rd(tmhp_pkg::TMHP_STAMP_LAST_ADDR, 16'h1234);
        rd(tmhp_pkg::TMHP_CTRL_ADDR, c27(4'hf, 1'b1, 1'b0));
        wr(tmhp_pkg::TMHP_CTRL_ADDR, 16'h0000);
        rd(tmhp_pkg::TMHP_CTRL_ADDR, c27(4'h0, 1'b0, 1'b0));
        wr(tmhp_pkg::TMHP_CTRL_ADDR, 16'h0008);
        repeat (8) @(negedge ref_clk_i);
        cmp_cnt("phase events", 3, ph_n);
        cmp_cnt("stamp captures", 2, st_n);
        cmp_cnt("reads left", 0, exp_q.size());
        end_of_test();
    end
endmodule
bind tmhp_port tmhp_monitor #(.DW(DW)) tmhp_monitor_inst (.ref_clk_i, .rst_i, .family_sel_i, .cs_n_i,
    .rd_n_i, .wr_n_i, .phase_in_i, .stamp_strobe_i, .data_o, .data_oe_n_o, .ready_n_o, .phase_event_o,
    .stamp_capture_o, .ctrl_user_o);

// ---- verif/tmhp_host.sv ----
// host processor model driving the parallel port pins
`timescale 1ns/1ps
module tmhp_host (
    input wire logic ref_clk_i,
    input wire logic family_sel_i,
    output logic mproc_clk_o,
    output logic cs_n_o,
    output logic rd_n_o,
    output logic wr_n_o,
    output logic [4:0] addr_o,
    output logic [15:0] data_o
);
    initial begin
        mproc_clk_o = 1'b0;
        cs_n_o = 1'b1;
        rd_n_o = 1'b1;
        wr_n_o = 1'b1;
        addr_o = 5'h00;
        data_o = 16'h0000;
    end
    // free running, far below the crystal rate
    always begin
        repeat (4) @(negedge ref_clk_i);
        mproc_clk_o <= ~mproc_clk_o;
    end
    task automatic mclk_edge(input logic rise);
        if (rise) @(posedge mproc_clk_o);
        else @(negedge mproc_clk_o);
    endtask
    // strobes change on the edge the device does not sample
    task automatic access(input logic wrt, input logic [4:0] a, input logic [15:0] d);
        mclk_edge(!family_sel_i);
        cs_n_o <= 1'b0;
        rd_n_o <= wrt;
        wr_n_o <= !wrt;
        addr_o <= a;
        data_o <= d;
        repeat (2) mclk_edge(family_sel_i);
        mclk_edge(!family_sel_i);
        cs_n_o <= 1'b1;
        rd_n_o <= 1'b1;
        wr_n_o <= 1'b1;
        addr_o <= ~a;
        data_o <= ~d;
        mclk_edge(family_sel_i);
        mclk_edge(!family_sel_i);
    endtask
endmodule

// ---- verif/tmhp_monitor.sv ----
// assertion checker watching the time manager host port pins
`timescale 1ns/1ps
module tmhp_monitor #(
    parameter int DW = 16
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic family_sel_i,
    input wire logic cs_n_i,
    input wire logic rd_n_i,
    input wire logic wr_n_i,
    input wire logic phase_in_i,
    input wire logic stamp_strobe_i,
    input wire logic [DW-1:0] data_o,
    input wire logic data_oe_n_o,
    input wire logic ready_n_o,
    input wire logic phase_event_o,
    input wire logic stamp_capture_o,
    input wire logic [3:0] ctrl_user_o
);
    // ****************************************
    // properties
    // ****************************************
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    property p_fam0_quiet;
        !family_sel_i && $past(!family_sel_i, 4) |-> ready_n_o;
    endproperty
    property p_fam1_ready;
        family_sel_i && $fell(data_oe_n_o) |-> !ready_n_o;
    endproperty
    // pins are seen through a synchroniser, hence the look back
    property p_read_take;
        $fell(data_oe_n_o) |-> $past(!cs_n_i && !rd_n_i && wr_n_i, 6);
    endproperty
    property p_user_cause;
        $changed(ctrl_user_o) |-> $past(!cs_n_i && !wr_n_i, 5);
    endproperty
    property p_data_stable;
        !data_oe_n_o && $past(!data_oe_n_o) |-> $stable(data_o);
    endproperty
    property p_phase_edge;
        $rose(phase_in_i) |-> ##[1:6] phase_event_o;
    endproperty
    property p_phase_pulse;
        phase_event_o |=> !phase_event_o;
    endproperty
    property p_stamp_edge;
        $rose(stamp_strobe_i) |-> ##[1:6] stamp_capture_o;
    endproperty
    a_fam0_quiet: assert property (p_fam0_quiet) else $error("ready low in falling family");
    a_fam1_ready: assert property (p_fam1_ready) else $error("ready missing on read");
    a_read_take: assert property (p_read_take) else $error("read without strobes");
    a_user_cause: assert property (p_user_cause) else $error("user bits changed without write");
    a_data_stable: assert property (p_data_stable) else $error("read word moved");
    a_phase_edge: assert property (p_phase_edge) else $error("phase edge lost");
    a_phase_pulse: assert property (p_phase_pulse) else $error("phase pulse too long");
    a_stamp_edge: assert property (p_stamp_edge) else $error("strobe edge lost");
    c_read_fam1: cover property (family_sel_i && $fell(data_oe_n_o));
    c_phase: cover property (phase_event_o);
    c_stamp: cover property (stamp_capture_o);
endmodule
